/* rcx_pkg.sv */
// constants and types for the exception and pipeline control unit
// How it works
// - sixteen bit status word, flag fields fixed
// - enables gate fast, normal, trace exceptions
// - arithmetic sets overflow, alu sets condition
// - zero flags track r6 and r7
// - privilege bit drives mode indicator output
// - protected bits writable only when privileged
// - only exceptions raise privilege from user
// - reserved status bits read zero
// - five stage pipeline, one per cycle
// - forward from execute and memory stages
// - load use costs one stall
// - taken plain branch stalls one cycle
// - memory port conflicts stall the pipeline
// - five exceptions, fixed priority, four fixed vectors
// - reset release jumps through word zero
// - reset leaves only privilege bit set
// - fast request saves state, clears enables
// - fast return restores status and pc
// - normal request saves, vectors, return restores
// - trace traps after each instruction but a soft trap
// - soft trap links, jumps immediate times four
// - big endian, wide value has zero byte
// - program address is pc bits 21..1
// - wait input freezes the core
// - global disable blocks all requests
// - pc and saved low lsb always zero
package rcx_pkg;
  // status word bit positions
  localparam int SW_T   = 15;
  localparam int SW_PM  = 6;
  localparam int SW_Z1  = 5;
  localparam int SW_Z0  = 4;
  localparam int SW_V   = 3;
  localparam int SW_TE  = 2;
  localparam int SW_IE  = 1;
  localparam int SW_FE  = 0;
  // reset value: privileged only
  localparam logic [15:0] SW_RESET    = 16'h0040;
  // reserved bits 14..7 masked off
  localparam logic [15:0] SW_USED     = 16'h807F;
  // exception vector byte addresses, words 0 to 3
  localparam logic [21:0] VEC_RESET   = 22'h000000;
  localparam logic [21:0] VEC_FAST    = 22'h000002;
  localparam logic [21:0] VEC_NORMAL  = 22'h000004;
  localparam logic [21:0] VEC_TRACE   = 22'h000006;
  localparam logic [21:0] PC_STEP     = 22'h000002;

  // one retiring instruction, told by the datapath
  typedef struct packed {
    logic        valid;       // an instruction completes this cycle
    logic        is_arith;    // updates overflow
    logic        is_alu;      // updates condition flag
    logic        ovf;         // overflow result
    logic        cond;        // condition result
    logic        sw_write;    // writes status word
    logic [15:0] sw_wdata;    // value to write
    logic        fast_ret;    // fast return
    logic        norm_ret;    // normal return
    logic        trap_ret;    // soft trap return
    logic        trap;        // soft trap
    logic [5:0]  trap_imm;    // soft trap immediate
    logic        taken;       // branch taken
    logic        delayed;     // branch owns a delay slot
    logic [21:0] target;      // branch or return target
  } rcx_retire_t;

  // hazard view of decode, execute and memory stages
  typedef struct packed {
    logic [3:0] id_src_a;     // decode source a
    logic [3:0] id_src_b;     // decode source b
    logic       id_alu;       // decode is an alu op
    logic       ex_load;      // execute stage is a load
    logic       ex_wr;        // execute writes a register
    logic [3:0] ex_dst;       // execute destination
    logic       mem_wr;       // memory writes a register
    logic [3:0] mem_dst;      // memory destination
    logic       ex_pm_load;   // load from program memory
    logic       ex_rmw;       // read modify write bit op
  } rcx_hazard_t;

  typedef enum logic [2:0] {
    EXC_NONE, EXC_RESET, EXC_TRACE, EXC_FAST, EXC_TRAP, EXC_NORMAL
  } rcx_exc_t;
endpackage

/* rcx_core_ctrl.sv */
// status word, exception sequencing and hazard control of the core
`timescale 1ns/10ps
`default_nettype none
module rcx_core_ctrl
  import rcx_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        fast_request_in_n,
  input  wire logic        normal_request_in_n,
  input  wire logic        wait_in_n,
  input  wire logic        global_int_disable_n,
  input  wire logic [15:0] prog_data,
  input  wire logic [15:0] reg_r6,
  input  wire logic [15:0] reg_r7,
  input  wire logic [21:0] link_value,
  input  wire rcx_retire_t retire,
  input  wire rcx_hazard_t hazard,
  output logic [20:0]      program_address_out,
  output logic             privilege_indicator_out,
  output logic [15:0]      status_word,
  output logic             stall,
  output logic [1:0]       fwd_a,
  output logic [1:0]       fwd_b,
  output logic             link_write,
  output logic [21:0]      link_data,
  output logic [31:0]      store_image
);
  // synchronisers for the asynchronous pins
  logic [1:0] fiq_s;
  logic [1:0] irq_s;
  logic [1:0] wait_s;
  logic [1:0] gid_s;
  logic       fiq_d;          // previous synced fast level
  logic       irq_d;          // previous synced normal level
  logic       fast_pend;      // latched fast request
  logic       norm_pend;      // latched normal request
  logic       rst_d;          // no reset seen last cycle
  logic       reset_pend;     // reset vector fetch due
  logic       trace_pend;     // trace trap due
  logic       vec_fetch;      // second cycle of vector fetch
  logic [21:0] program_counter;
  logic [21:0] next_pc;
  logic [15:0] next_sw;
  logic [15:0] fast_saved_status;
  logic [15:0] normal_saved_status;
  logic [15:0] trap_saved_status;
  logic [5:0]  fast_saved_pc_high;
  logic [15:0] fast_saved_pc_low;
  logic [5:0]  normal_saved_pc_high;
  logic [15:0] normal_saved_pc_low;
  rcx_exc_t    exc_sel;       // exception taken this cycle
  logic        run;           // core not held by wait
  logic        load_use;
  logic        port_conflict;
  logic        branch_bubble;
  logic        bubble_d;      // one cycle branch stall already spent

  // two flip flop synchronisers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fiq_s  <= 2'h3;
      irq_s  <= 2'h3;
      wait_s <= 2'h3;
      gid_s  <= 2'h3;
    end else begin
      fiq_s  <= {fiq_s[0], fast_request_in_n};
      irq_s  <= {irq_s[0], normal_request_in_n};
      wait_s <= {wait_s[0], wait_in_n};
      gid_s  <= {gid_s[0], global_int_disable_n};
    end
  end

  assign run = wait_s[1];

  // falling edge capture of requests; edge wins over consumption
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fiq_d     <= 1'b1;
      irq_d     <= 1'b1;
      fast_pend <= 1'b0;
      norm_pend <= 1'b0;
    end else begin
      fiq_d <= fiq_s[1];
      irq_d <= irq_s[1];
      if (fiq_d && !fiq_s[1] && gid_s[1]) begin
        fast_pend <= 1'b1;
      end else if (exc_sel == EXC_FAST || !gid_s[1]) begin
        fast_pend <= 1'b0;
      end
      if (irq_d && !irq_s[1] && gid_s[1]) begin
        norm_pend <= 1'b1;
      end else if (exc_sel == EXC_NORMAL || !gid_s[1]) begin
        norm_pend <= 1'b0;
      end
    end
  end

  // reset release and trace pending
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rst_d      <= 1'b0;
      reset_pend <= 1'b0;
      trace_pend <= 1'b0;
    end else begin
      rst_d <= 1'b1;
      if (!rst_d) begin
        reset_pend <= 1'b1;
      end else if (exc_sel == EXC_RESET) begin
        reset_pend <= 1'b0;
      end
      if (run && retire.valid && status_word[SW_TE] && !retire.trap) begin
        trace_pend <= 1'b1;
      end else if (exc_sel == EXC_TRACE) begin
        trace_pend <= 1'b0;
      end
    end
  end

  // priority select; lower ones stay pending
  always_comb begin
    exc_sel = EXC_NONE;
    if (!run || vec_fetch) begin
      exc_sel = EXC_NONE;
    end else if (reset_pend) begin
      exc_sel = EXC_RESET;
    end else if (trace_pend) begin
      exc_sel = EXC_TRACE;
    end else if (fast_pend && status_word[SW_FE]) begin
      exc_sel = EXC_FAST;
    end else if (retire.valid && retire.trap) begin
      exc_sel = EXC_TRAP;
    end else if (norm_pend && status_word[SW_IE]) begin
      exc_sel = EXC_NORMAL;
    end
  end

  // next status word
  always_comb begin
    next_sw = status_word;
    case (exc_sel)
      EXC_FAST: begin
        next_sw[SW_PM] = 1'b1;
        next_sw[SW_FE] = 1'b0;
        next_sw[SW_IE] = 1'b0;
        next_sw[SW_TE] = 1'b0;
      end
      EXC_TRACE, EXC_NORMAL, EXC_TRAP: begin
        next_sw[SW_PM] = 1'b1;
        next_sw[SW_IE] = 1'b0;
        next_sw[SW_TE] = 1'b0;
      end
      EXC_RESET: begin
        next_sw = SW_RESET;
      end
      default: begin
        if (retire.valid && retire.fast_ret) begin
          next_sw = fast_saved_status;
        end else if (retire.valid && retire.norm_ret) begin
          next_sw = normal_saved_status;
        end else if (retire.valid && retire.trap_ret) begin
          next_sw = trap_saved_status;
        end else if (retire.valid && retire.sw_write) begin
          next_sw[SW_T] = retire.sw_wdata[SW_T];
          next_sw[SW_V] = retire.sw_wdata[SW_V];
          if (status_word[SW_PM]) begin
            next_sw[SW_PM] = retire.sw_wdata[SW_PM];
            next_sw[SW_FE] = retire.sw_wdata[SW_FE];
            next_sw[SW_IE] = retire.sw_wdata[SW_IE];
            next_sw[SW_TE] = retire.sw_wdata[SW_TE];
          end
        end else if (retire.valid) begin
          if (retire.is_arith) begin
            next_sw[SW_V] = retire.ovf;
          end
          if (retire.is_alu) begin
            next_sw[SW_T] = retire.cond;
          end
        end
        // a return cannot lift a user-mode core into privileged mode
        if (!status_word[SW_PM]) begin
          next_sw[SW_PM] = 1'b0;
        end
      end
    endcase
    next_sw[SW_Z0] = (reg_r6 == 16'h0000);
    next_sw[SW_Z1] = (reg_r7 == 16'h0000);
    next_sw = next_sw & SW_USED;
  end

  // status word register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      status_word <= SW_RESET;
    end else if (run) begin
      status_word <= next_sw;
    end
  end

  // saved state on exception entry; pc lsb forced to zero
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fast_saved_status    <= 16'h0000;
      normal_saved_status  <= 16'h0000;
      trap_saved_status    <= 16'h0000;
      fast_saved_pc_high   <= 6'h00;
      fast_saved_pc_low    <= 16'h0000;
      normal_saved_pc_high <= 6'h00;
      normal_saved_pc_low  <= 16'h0000;
    end else if (exc_sel == EXC_FAST) begin
      fast_saved_status  <= status_word;
      fast_saved_pc_high <= program_counter[21:16];
      fast_saved_pc_low  <= {program_counter[15:1], 1'b0};
    end else if (exc_sel == EXC_NORMAL || exc_sel == EXC_TRACE) begin
      normal_saved_status  <= status_word;
      normal_saved_pc_high <= program_counter[21:16];
      normal_saved_pc_low  <= {program_counter[15:1], 1'b0};
    end else if (exc_sel == EXC_TRAP) begin
      trap_saved_status <= status_word;
    end
  end

  // soft trap link to the address register file
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      link_write <= 1'b0;
      link_data  <= 22'h000000;
    end else begin
      link_write <= (exc_sel == EXC_TRAP);
      link_data  <= {program_counter[21:1], 1'b0};
    end
  end

  // hazard detection
  always_comb begin
    load_use = hazard.id_alu && hazard.ex_load && hazard.ex_wr &&
               (hazard.ex_dst == hazard.id_src_a ||
                hazard.ex_dst == hazard.id_src_b);
    port_conflict = hazard.ex_pm_load || hazard.ex_rmw;
    branch_bubble = retire.valid && retire.taken && !retire.delayed &&
                    !bubble_d;
  end

  // stall and forward selects, registered
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stall    <= 1'b0;
      bubble_d <= 1'b0;
      fwd_a    <= 2'h0;
      fwd_b    <= 2'h0;
    end else begin
      stall    <= !run || load_use || port_conflict || branch_bubble;
      bubble_d <= branch_bubble;
      // 1 selects execute result, 2 memory result
      fwd_a <= (hazard.ex_wr && hazard.ex_dst == hazard.id_src_a) ? 2'h1 :
               (hazard.mem_wr && hazard.mem_dst == hazard.id_src_a) ? 2'h2 :
               2'h0;
      fwd_b <= (hazard.ex_wr && hazard.ex_dst == hazard.id_src_b) ? 2'h1 :
               (hazard.mem_wr && hazard.mem_dst == hazard.id_src_b) ? 2'h2 :
               2'h0;
    end
  end

  // next program counter
  always_comb begin
    next_pc = program_counter;
    case (exc_sel)
      EXC_RESET:  next_pc = VEC_RESET;
      EXC_TRACE:  next_pc = VEC_TRACE;
      EXC_FAST:   next_pc = VEC_FAST;
      EXC_NORMAL: next_pc = VEC_NORMAL;
      EXC_TRAP:   next_pc = {14'h0000, retire.trap_imm, 2'h0};
      default: begin
        if (vec_fetch) begin
          next_pc = {6'h00, prog_data};
        end else if (retire.valid && retire.fast_ret) begin
          next_pc = {fast_saved_pc_high, fast_saved_pc_low};
        end else if (retire.valid && retire.norm_ret) begin
          next_pc = {normal_saved_pc_high, normal_saved_pc_low};
        end else if (retire.valid && (retire.trap_ret || retire.taken)) begin
          next_pc = retire.target;
        end else if (!load_use && !port_conflict && !branch_bubble) begin
          next_pc = program_counter + PC_STEP;
        end
      end
    endcase
    next_pc[0] = 1'b0;
  end

  // program counter and vector fetch phase
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      program_counter <= 22'h000000;
      vec_fetch       <= 1'b0;
    end else if (run) begin
      program_counter <= next_pc;
      vec_fetch       <= (exc_sel != EXC_NONE) && (exc_sel != EXC_TRAP);
    end
  end

  // registered outputs
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      program_address_out     <= 21'h000000;
      privilege_indicator_out <= 1'b1;
      store_image             <= 32'h00000000;
    end else begin
      // held under wait so they keep tracking the frozen pc and status
      if (run) begin
        program_address_out     <= next_pc[21:1];
        privilege_indicator_out <= next_sw[SW_PM];
      end
      // zero byte, then the 22-bit value padded to three bytes
      store_image <= {8'h00, 2'h0, link_value};
    end
  end

  // checks
  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (status_word & ~SW_USED) == 16'h0000) else $error("reserved bits set");
  a_user_locked: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!status_word[SW_PM] && exc_sel == EXC_NONE) |=> !status_word[SW_PM])
    else $error("privilege raised without exception");
  a_fast_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exc_sel == EXC_FAST |=> status_word[SW_PM] && !status_word[SW_FE] &&
    !status_word[SW_IE] && !status_word[SW_TE]) else $error("fast entry bad");
  a_normal_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exc_sel == EXC_NORMAL |=> program_counter == VEC_NORMAL &&
    fast_saved_status == $past(fast_saved_status)) else $error("normal entry bad");
  a_pc_lsb: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !program_counter[0] && !fast_saved_pc_low[0] && !normal_saved_pc_low[0])
    else $error("pc lsb set");
  a_wait_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !run |=> $stable(program_counter) && $stable(status_word))
    else $error("state moved under wait");
  a_pa_track: assert property (@(posedge ref_clk) disable iff (!rst_n)
    1'b1 |=> program_address_out == program_counter[21:1])
    else $error("program address mismatch");
  a_pm_out: assert property (@(posedge ref_clk) disable iff (!rst_n)
    1'b1 |=> privilege_indicator_out == status_word[SW_PM])
    else $error("mode indicator wrong");
  a_trap_target: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exc_sel == EXC_TRAP |=> program_counter == {14'h0000, $past(retire.trap_imm), 2'h0}
    && link_write) else $error("trap target wrong");
  a_prio_trace: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (run && !vec_fetch && !reset_pend && trace_pend) |-> exc_sel == EXC_TRACE)
    else $error("trace not first");
  // vector entry in two steps: vector address, then the word read there
  sequence s_vec_taken;
    exc_sel != EXC_NONE && exc_sel != EXC_TRAP;
  endsequence
  sequence s_vec_word;
    program_counter == {6'h00, $past(prog_data[15:1]), 1'b0};
  endsequence
  a_vector_phase: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_vec_taken |=> vec_fetch) else $error("vector phase missing");
  a_vector_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (vec_fetch && run) |=> s_vec_word) else $error("vector word not loaded");
  // trace entry saves into the normal slots
  a_trace_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exc_sel == EXC_TRACE |=> program_counter == VEC_TRACE && status_word[SW_PM] &&
    !status_word[SW_IE] && !status_word[SW_TE] &&
    normal_saved_status == $past(status_word)) else $error("trace entry bad");
  // soft trap hands the return address to the link register
  a_trap_link: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exc_sel == EXC_TRAP |=> link_data == {$past(program_counter[21:1]), 1'b0})
    else $error("trap link wrong");
  a_fast_return: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (run && !vec_fetch && exc_sel == EXC_NONE && retire.valid && retire.fast_ret) |=>
    program_counter == $past({fast_saved_pc_high, fast_saved_pc_low}))
    else $error("fast return pc wrong");
  // stall checks
  a_load_stall: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (run && load_use) |=> stall) else $error("load use not stalled");
  a_delay_slot: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (run && retire.valid && retire.taken && retire.delayed && !load_use &&
    !port_conflict) |=> !stall) else $error("delay slot stalled");
endmodule
`default_nettype wire

/* rcx_prog_model.sv */
// program memory model that answers the vector fetches of the core
`timescale 1ns/10ps
`default_nettype none
module rcx_prog_model (
  input  wire logic [20:0] program_address_out,
  output logic      [15:0] prog_data
);
  // each word holds an even handler address built from the low eleven bits of its index
  assign prog_data = {4'h1, program_address_out[10:0], 1'b0};
endmodule
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the core status, exception and hazard control
`timescale 1ns/10ps
`default_nettype none
module tb_top import rcx_pkg::*; ;
  typedef struct packed {
    logic [15:0] w;    // status value written
    logic        z6;   // register six is zero
    logic        z7;   // register seven is zero
    logic [15:0] exp;  // status expected after the write
  } rcx_row_t;
  typedef struct packed {
    rcx_hazard_t h;    // hazard view driven
    logic        st;   // stall expected
    logic        cf;   // forwarding selects are checked
  } rcx_hrow_t;
  logic        ref_clk;
  logic        rst_n;
  logic        fast_request_in_n;
  logic        normal_request_in_n;
  logic        wait_in_n;
  logic        global_int_disable_n;
  logic [15:0] prog_data;
  logic [15:0] reg_r6;
  logic [15:0] reg_r7;
  logic [21:0] link_value;
  rcx_retire_t retire;
  rcx_hazard_t hazard;
  logic [20:0] program_address_out;
  logic        privilege_indicator_out;
  logic [15:0] status_word;
  logic        stall;
  logic [1:0]  fwd_a;
  logic [1:0]  fwd_b;
  logic        link_write;
  logic [21:0] link_data;
  logic [31:0] store_image;
  int          mismatches;
  int          n_tests;
  rcx_retire_t r;
  logic [20:0] pa_seen;
  // status writes: privileged, zero flags, reserved bits, then user mode
  rcx_row_t rows [6] = '{
    '{16'h8043, 1'b0, 1'b0, 16'h8043}, '{16'h0041, 1'b1, 1'b0, 16'h0051},
    '{16'h0040, 1'b0, 1'b1, 16'h0060}, '{16'hFF80, 1'b0, 1'b0, 16'h8000},
    '{16'h0047, 1'b0, 1'b0, 16'h0000}, '{16'h8048, 1'b0, 1'b0, 16'h8008}};
  // load-use, forwarding, program memory load, read-modify-write
  rcx_hrow_t hrows [4] = '{
    '{'{4'h3, 4'h0, 1'b1, 1'b1, 1'b1, 4'h3, 1'b0, 4'h0, 1'b0, 1'b0}, 1'b1, 1'b0},
    '{'{4'h3, 4'h4, 1'b1, 1'b0, 1'b1, 4'h3, 1'b1, 4'h4, 1'b0, 1'b0}, 1'b0, 1'b1},
    '{'{4'h0, 4'h0, 1'b0, 1'b0, 1'b0, 4'h0, 1'b0, 4'h0, 1'b1, 1'b0}, 1'b1, 1'b0},
    '{'{4'h0, 4'h0, 1'b0, 1'b0, 1'b0, 4'h0, 1'b0, 4'h0, 1'b0, 1'b1}, 1'b1, 1'b0}};

  rcx_core_ctrl dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .fast_request_in_n(fast_request_in_n),
    .normal_request_in_n(normal_request_in_n), .wait_in_n(wait_in_n),
    .global_int_disable_n(global_int_disable_n), .prog_data(prog_data),
    .reg_r6(reg_r6), .reg_r7(reg_r7), .link_value(link_value), .retire(retire),
    .hazard(hazard), .program_address_out(program_address_out),
    .privilege_indicator_out(privilege_indicator_out), .status_word(status_word),
    .stall(stall), .fwd_a(fwd_a), .fwd_b(fwd_b), .link_write(link_write),
    .link_data(link_data), .store_image(store_image));
  rcx_prog_model mem (.program_address_out(program_address_out), .prog_data(prog_data));

  // free-running 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // compare a value, zero-extended to 32 bits
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // compare a single flag
  task automatic chk_bit(input logic got, input logic exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask

  // verdict and end of run
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // bounded wait for the program address to reach a value
  task automatic wait_pa(input logic [20:0] exp, input int n);
    bit hit;
    hit = 1'b0;
    for (int i = 0; i < n && !hit; i++) begin
      #1;
      if (program_address_out === exp) hit = 1'b1;
      else @(posedge ref_clk);
    end
    chk_bit(hit, 1'b1);
    if (!hit) summarize();
  endtask

  // the program address must stay off a vector for n cycles
  task automatic no_pa(input logic [20:0] bad, input int n);
    bit hit;
    hit = 1'b0;
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      if (program_address_out === bad) hit = 1'b1;
    end
    chk_bit(hit, 1'b0);
  endtask

  // one retiring instruction, sampled at the second edge
  task automatic issue(input rcx_retire_t ri);
    @(posedge ref_clk);
    retire <= ri;
    @(posedge ref_clk);
    retire <= '0;
  endtask

  // retire and let the status settle
  task automatic do_ret(input rcx_retire_t ri);
    issue(ri);
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  // status write carried by a retiring instruction
  function automatic rcx_retire_t wr(input logic [15:0] v);
    rcx_retire_t x;
    x = '0;
    x.valid = 1'b1;
    x.sw_write = 1'b1;
    x.sw_wdata = v;
    return x;
  endfunction

  // reset with checks of the held values and the jump through word zero
  task automatic do_reset();
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk_val(status_word, 16'h0040);
    chk_bit(privilege_indicator_out, 1'b1);
    chk_bit(stall, 1'b0);
    chk_val(program_address_out, 21'h000000);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    wait_pa(21'h000800, 10);
    $display("test reset done");
  endtask

  // main sequence
  initial begin
    rst_n = 1'b0;
    fast_request_in_n = 1'b1;
    normal_request_in_n = 1'b1;
    wait_in_n = 1'b1;
    global_int_disable_n = 1'b1;
    reg_r6 = 16'h0001;
    reg_r7 = 16'h0001;
    link_value = '0;
    retire = '0;
    hazard = '0;
    mismatches = 0;
    n_tests = 0;
    do_reset();
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < 6; i++) begin
      @(posedge ref_clk);
      reg_r6 <= rows[i].z6 ? 16'h0000 : 16'h0001;
      reg_r7 <= rows[i].z7 ? 16'h0000 : 16'h0001;
      do_ret(wr(rows[i].w));
      chk_val(status_word, rows[i].exp);
      chk_bit(privilege_indicator_out, rows[i].exp[SW_PM]);
    end
    $display("test status writes done");
    // soft trap from user mode: jump to imm*4, privileged, link pulse
    r = '0;
    r.valid = 1'b1;
    r.trap = 1'b1;
    r.trap_imm = 6'h05;
    @(posedge ref_clk);
    retire <= r;
    #1;
    pa_seen = program_address_out;
    @(posedge ref_clk);
    retire <= '0;
    wait_pa(21'h00000A, 4);
    chk_val(status_word, 16'h8048);
    chk_bit(link_write, 1'b1);
    chk_val(link_data, {pa_seen, 1'b0});
    $display("test soft trap done");
    // fast request with its enable set, then fast return
    do_ret(wr(16'h0041));
    @(posedge ref_clk);
    fast_request_in_n <= 1'b0;
    wait_pa(21'h000001, 12);
    chk_val(status_word, 16'h0040);
    @(posedge ref_clk);
    #1;
    chk_val(program_address_out, 21'h000801);
    fast_request_in_n <= 1'b1;
    r = '0;
    r.valid = 1'b1;
    r.fast_ret = 1'b1;
    do_ret(r);
    chk_val(status_word, 16'h0041);
    $display("test fast exception done");
    // normal request masked until its enable is written
    @(posedge ref_clk);
    normal_request_in_n <= 1'b0;
    no_pa(21'h000002, 10);
    normal_request_in_n <= 1'b1;
    issue(wr(16'h0043));
    wait_pa(21'h000002, 10);
    chk_val(status_word, 16'h0041);
    r = '0;
    r.valid = 1'b1;
    r.norm_ret = 1'b1;
    do_ret(r);
    chk_val(status_word, 16'h0043);
    $display("test normal exception done");
    // trace on: one plain instruction traps through its vector
    do_ret(wr(16'h0047));
    r = '0;
    r.valid = 1'b1;
    issue(r);
    wait_pa(21'h000003, 4);
    chk_val(status_word, 16'h0041);
    do_ret(wr(16'h0043));
    $display("test trace done");
    // global disable drops a request even after it lifts
    global_int_disable_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    normal_request_in_n <= 1'b0;
    no_pa(21'h000002, 10);
    normal_request_in_n <= 1'b1;
    global_int_disable_n <= 1'b1;
    no_pa(21'h000002, 10);
    $display("test global disable done");
    // wait freezes the status and stalls
    wait_in_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    do_ret(wr(16'h8040));
    chk_val(status_word, 16'h0043);
    chk_bit(stall, 1'b1);
    wait_in_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    $display("test wait done");
    // hazards: one stall cycle each except forwarding, whose selects are checked
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      hazard <= hrows[i].h;
      @(posedge ref_clk);
      hazard <= '0;
      #1;
      chk_bit(stall, hrows[i].st);
      if (hrows[i].cf) chk_val({fwd_b, fwd_a}, 4'h9);
      @(posedge ref_clk);
      #1;
      chk_bit(stall, 1'b0);
    end
    // taken branches: plain one costs a stall, delayed one none
    for (int d = 0; d < 2; d++) begin
      r = '0;
      r.valid = 1'b1;
      r.taken = 1'b1;
      r.delayed = d[0];
      r.target = 22'h000200;
      issue(r);
      #1;
      chk_bit(stall, ~d[0]);
      repeat (2) @(posedge ref_clk);
    end
    $display("test hazards done");
    // wide value stored with a leading zero byte
    link_value <= 22'h123456;
    repeat (2) @(posedge ref_clk);
    #1;
    chk_val(store_image, 32'h00123456);
    $display("test store image done");
    do_reset();
    summarize();
  end
endmodule
`default_nettype wire
